// ===== common/fcdma_pkg.sv
/*
  fcdma_pkg: shared types and constants of the four-channel transfer
  controller. Assumes one system clock and no register bus.
*/
package fcdma_pkg;
  localparam int NUM_CH         = 4;
  localparam int ADDR_W         = 32;
  localparam int SEL_W          = 6;
  localparam int CNT_W          = 16;
  // region codes for bus-width choice
  localparam logic [1:0] REG_PERI  = 2'h0;
  localparam logic [1:0] REG_RAM   = 2'h1;
  localparam logic [1:0] REG_EXT8  = 2'h2;
  localparam logic [1:0] REG_EXT16 = 2'h3;
  // bus widths in bits
  localparam int W_PERI = 16;
  localparam int W_RAM  = 32;
  // timing: least response length in ns and clocks, access lengths in clocks
  localparam int CLK_PERIOD_NS  = 4;
  localparam int RESP_MIN_NS    = 16;
  localparam int RESP_MIN_CYC   = (RESP_MIN_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int RAM_ACC_CYC    = 2;
  localparam int PERI_ACC_CYC   = 3;
  localparam int EXT_ACC_CYC    = 2;
  localparam int IDLE_CYC       = 1;
  localparam logic [SEL_W-1:0] SEL_NONE = 6'h00;
  localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;

  // per-channel configuration
  typedef struct packed {
    logic              enable;
    logic              half;       // transfer size: 1 = halfword
    logic [1:0]        src_region;
    logic [1:0]        dst_region;
    logic [SEL_W-1:0]  source_sel;
    logic [ADDR_W-1:0] src_addr;
    logic [ADDR_W-1:0] dst_addr;
    logic [CNT_W-1:0]  count;
  } fcdma_cfg_s;

  // one bus cycle request towards the system bus
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [1:0]        size;       // 0 byte, 1 halfword
    logic [15:0]       wdata;
  } fcdma_bus_s;
endpackage : fcdma_pkg

// ===== logic/fcdma_fifo.sv
/*
  fcdma_fifo: flip-flop FIFO with valid/ready on both sides.
  Assumes a single clock; full and empty are exact.
*/
`timescale 1ns/1ps
module fcdma_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  ////////////////////////////////////////////////////////////////////////
  // storage and pointers; wrap is explicit so depth need not be 2^n
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : fcdma_fifo

// ===== logic/fcdma_chan.sv
/*
  fcdma_chan: request and completion state of one channel.
  Assumes trigger inputs already synchronous; irq pins are filtered
  upstream by the pin's own noise filter.
*/
`timescale 1ns/1ps
module fcdma_chan
  import fcdma_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             enable,
  input  wire logic [SEL_W-1:0] source_sel,
  input  wire logic [63:0]      periph_irq,
  input  wire logic             soft_trigger_bit,
  input  wire logic             flag_read,
  input  wire logic [CNT_W-1:0] count_init,
  input  wire logic             count_load,
  input  wire logic             granted,
  input  wire logic             unit_done,
  output logic                  request_pending_flag,
  output logic                  terminal_count_flag,
  output logic                  enable_clear,
  output logic                  transfer_end_irq,
  output logic [CNT_W-1:0]      transfer_count_reg
);
  logic hw_hit;
  logic in_flight;
  logic last_unit;

  assign hw_hit    = (source_sel != SEL_NONE) && periph_irq[source_sel];
  assign last_unit = unit_done && (transfer_count_reg == CNT_W'(1));

  ////////////////////////////////////////////////////////////////////////
  // pending flag: a hardware trigger sets it even when disabled; one
  // trigger wins when both arrive, and repeats while busy are dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      request_pending_flag <= 1'b0;
      in_flight            <= 1'b0;
    end else begin
      if (granted) begin
        request_pending_flag <= 1'b0;
        in_flight            <= 1'b1;
      end else if (!request_pending_flag && !in_flight) begin
        if (hw_hit) begin
          request_pending_flag <= 1'b1;
        end else if (soft_trigger_bit && enable
                     && !terminal_count_flag) begin
          request_pending_flag <= 1'b1;
        end
      end
      if (unit_done) begin
        in_flight <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // count, terminal flag and end interrupt; set beats read-clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transfer_count_reg  <= CNT_RST;
      terminal_count_flag <= 1'b0;
      transfer_end_irq    <= 1'b0;
      enable_clear        <= 1'b0;
    end else begin
      transfer_end_irq <= last_unit;
      enable_clear     <= last_unit;
      if (count_load) begin
        transfer_count_reg <= count_init;
      end else if (unit_done) begin
        transfer_count_reg <= transfer_count_reg - CNT_W'(1);
      end
      if (last_unit) begin
        terminal_count_flag <= 1'b1;
      end else if (flag_read) begin
        terminal_count_flag <= 1'b0;
      end
    end
  end

  a_tc_on_last: assert property (@(posedge clk) disable iff (rst)
    last_unit |=> terminal_count_flag && transfer_end_irq)
    else $error("terminal flag not set after last unit");
  a_busy_drop: assert property (@(posedge clk) disable iff (rst)
    in_flight && !unit_done |=> !request_pending_flag)
    else $error("request latched while channel busy");
  a_read_clear: assert property (@(posedge clk) disable iff (rst)
    flag_read && !last_unit |=> !terminal_count_flag)
    else $error("terminal flag survived a read");
endmodule : fcdma_chan

// ===== logic/fcdma_top.sv
/*
  fcdma_top: four-channel transfer controller, bus master on the
  shared system bus. Assumes the bus answers each cycle with bus_ack
  no earlier than the documented access length and that the CPU owns
  the bus whenever bus_grant is low.
*/
`timescale 1ns/1ps
module fcdma_top
  import fcdma_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire fcdma_pkg::fcdma_cfg_s [3:0]   cfg,
  input  wire logic [3:0]                    cfg_load,
  input  wire logic [3:0]                    soft_trigger_bit,
  input  wire logic [3:0]                    flag_read,
  input  wire logic [63:0]                   periph_irq,
  input  wire logic [3:0]                    system_wait_setting,
  input  wire logic                          bus_hold,
  input  wire logic                          bus_ack,
  input  wire logic [15:0]                   bus_rdata,
  output logic                               bus_req,
  output logic                               bus_grant,
  output fcdma_pkg::fcdma_bus_s              bus_cmd,
  output logic                               bus_valid,
  output logic [3:0]                         request_pending_flag,
  output logic [3:0]                         terminal_count_flag,
  output logic [3:0]                         enable_clear,
  output logic [3:0]                         transfer_end_irq,
  output logic [3:0][15:0]                   transfer_count_reg
);
  typedef enum logic [2:0] {
    S_IDLE, S_RESP, S_READ, S_GAP, S_WRITE, S_REL
  } fcdma_state_e;

  fcdma_state_e       state;
  logic [1:0]         cur_ch;
  logic [3:0]         granted;
  logic [3:0]         unit_done;
  logic [3:0]         eligible;
  logic               any_req;
  logic [1:0]         win_ch;
  logic [2:0]         rd_total;
  logic [2:0]         wr_total;
  logic [2:0]         rd_cnt;
  logic [2:0]         wr_cnt;
  logic [3:0]         wait_cnt;
  logic [3:0]         acc_len;
  logic [ADDR_W-1:0]  src_a;
  logic [ADDR_W-1:0]  dst_a;
  logic               rd_byte;
  logic               wr_byte;
  logic [15:0]        assembled;
  logic [15:0]        fifo_out;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic               fifo_pop;
  logic               cur_half;
  logic [1:0]         cur_src;
  logic [1:0]         cur_dst;
  logic [ADDR_W-1:0]  src_base;
  logic [ADDR_W-1:0]  dst_base;
  logic               hold_meta;
  logic               hold_q2;
  logic               hold_q3;
  logic               hold_on;

  ////////////////////////////////////////////////////////////////////////
  // per-channel request and completion logic
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    fcdma_chan u_chan (
      .clk                  (clk),
      .rst                  (rst),
      .enable               (cfg[i].enable),
      .source_sel           (cfg[i].source_sel),
      .periph_irq           (periph_irq),
      .soft_trigger_bit     (soft_trigger_bit[i]),
      .flag_read            (flag_read[i]),
      .count_init           (cfg[i].count),
      .count_load           (cfg_load[i]),
      .granted              (granted[i]),
      .unit_done            (unit_done[i]),
      .request_pending_flag (request_pending_flag[i]),
      .terminal_count_flag  (terminal_count_flag[i]),
      .enable_clear         (enable_clear[i]),
      .transfer_end_irq     (transfer_end_irq[i]),
      .transfer_count_reg   (transfer_count_reg[i])
    );
    // pending but disabled channels wait; enabling starts them
    assign eligible[i] = request_pending_flag[i] && cfg[i].enable
                         && !terminal_count_flag[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // fixed priority pick, lowest index wins
  always_comb begin
    any_req = |eligible;
    win_ch  = 2'h0;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (eligible[k]) begin
        win_ch = 2'(k);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus hold pin: three stages, change taken when stage 2 and 3 agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_meta <= 1'b0;
      hold_q2   <= 1'b0;
      hold_q3   <= 1'b0;
      hold_on   <= 1'b0;
    end else begin
      hold_meta <= bus_hold;
      hold_q2   <= hold_meta;
      hold_q3   <= hold_q2;
      if (hold_q2 == hold_q3) begin
        hold_on <= hold_q3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cycle plan from region widths and transfer size
  always_comb begin
    rd_byte  = (cur_src == REG_EXT8);
    wr_byte  = (cur_dst == REG_EXT8);
    rd_total = 3'h1;
    wr_total = 3'h1;
    if (cur_half && rd_byte) begin
      rd_total = 3'h2;
    end
    if (cur_half && wr_byte) begin
      wr_total = 3'h2;
    end
    // 32->16 and 16->32 stay one read and one write
    if (state == S_WRITE) begin
      unique case (cur_dst)
        REG_RAM:  acc_len = 4'(RAM_ACC_CYC);
        REG_PERI: acc_len = 4'(PERI_ACC_CYC) + system_wait_setting;
        default:  acc_len = 4'(EXT_ACC_CYC);
      endcase
    end else begin
      unique case (cur_src)
        REG_RAM:  acc_len = 4'(RAM_ACC_CYC);
        REG_PERI: acc_len = 4'(PERI_ACC_CYC) + system_wait_setting;
        default:  acc_len = 4'(EXT_ACC_CYC);
      endcase
    end
  end

  // halfword cycles use an even address; byte halves step by one
  assign src_a = (cur_half ? {src_base[ADDR_W-1:1], 1'b0} : src_base)
                 + ADDR_W'(rd_cnt);
  assign dst_a = (cur_half ? {dst_base[ADDR_W-1:1], 1'b0} : dst_base)
                 + ADDR_W'(wr_cnt);

  ////////////////////////////////////////////////////////////////////////
  // transfer sequencer: respond, read, idle, write, release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state     <= S_IDLE;
      cur_ch    <= 2'h0;
      rd_cnt    <= 3'h0;
      wr_cnt    <= 3'h0;
      wait_cnt  <= 4'h0;
      cur_half  <= 1'b0;
      cur_src   <= REG_PERI;
      cur_dst   <= REG_PERI;
      src_base  <= '0;
      dst_base  <= '0;
      assembled <= 16'h0000;
    end else begin
      unique case (state)
        S_IDLE: begin
          // bus is with the CPU here, so a new pick sees all requests
          if (any_req && !hold_on) begin
            state    <= S_RESP;
            cur_ch   <= win_ch;
            cur_half <= cfg[win_ch].half;
            cur_src  <= cfg[win_ch].src_region;
            cur_dst  <= cfg[win_ch].dst_region;
            src_base <= cfg[win_ch].src_addr;
            dst_base <= cfg[win_ch].dst_addr;
            wait_cnt <= 4'(RESP_MIN_CYC - 1);
            rd_cnt   <= 3'h0;
            wr_cnt   <= 3'h0;
          end
        end
        S_RESP: begin
          if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
          end else if (!hold_on) begin
            state <= S_READ;
          end
        end
        S_READ: begin
          if (hold_on) begin
            state  <= S_RESP; // restart unit after hold
            rd_cnt <= 3'h0;
          end else if (bus_ack && fifo_in_ready) begin
            if (rd_byte && cur_half) begin
              assembled <= rd_cnt[0] ? {bus_rdata[7:0], assembled[7:0]}
                                     : {8'h00, bus_rdata[7:0]};
            end
            rd_cnt <= rd_cnt + 3'h1;
            if (rd_cnt + 3'h1 == rd_total) begin
              state <= S_GAP;
            end
          end
        end
        S_GAP: begin
          state <= S_WRITE; // exactly one idle clock
        end
        S_WRITE: begin
          if (hold_on) begin
            state  <= S_GAP; // write again after hold
            wr_cnt <= 3'h0;
          end else if (bus_ack && fifo_out_valid) begin
            wr_cnt <= wr_cnt + 3'h1;
            if (wr_cnt + 3'h1 == wr_total) begin
              state <= S_REL;
            end
          end
        end
        S_REL: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  assign granted   = (state == S_IDLE && any_req && !hold_on)
                     ? (4'h1 << win_ch) : 4'h0;
  assign unit_done = (state == S_REL) ? (4'h1 << cur_ch) : 4'h0;
  assign bus_req   = (state != S_IDLE);
  assign bus_grant = (state == S_READ) || (state == S_GAP)
                     || (state == S_WRITE);
  assign bus_valid = (state == S_READ) || (state == S_WRITE);
  assign fifo_pop  = (state == S_WRITE) && bus_ack && !hold_on
                     && (wr_cnt + 3'h1 == wr_total);

  ////////////////////////////////////////////////////////////////////////
  // data path buffer between read and write cycles; a full buffer
  // stalls the read cycle
  fcdma_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   ((rd_byte && cur_half) ? {bus_rdata[7:0], assembled[7:0]}
                                      : bus_rdata),
    .in_valid  (state == S_READ && bus_ack && !hold_on
                && (rd_cnt + 3'h1 == rd_total)),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  // bus command: limitation, address width checks are left to software
  always_comb begin
    bus_cmd.write = (state == S_WRITE);
    bus_cmd.addr  = (state == S_WRITE) ? dst_a : src_a;
    bus_cmd.size  = ((state == S_WRITE) ? wr_byte : rd_byte)
                    || !cur_half ? 2'h0 : 2'h1;
    bus_cmd.wdata = (wr_byte && cur_half)
                    ? (wr_cnt[0] ? {8'h00, fifo_out[15:8]}
                                 : {8'h00, fifo_out[7:0]})
                    : fifo_out;
  end

  ////////////////////////////////////////////////////////////////////////
  // bus and arbitration checks
  a_gap_one: assert property (@(posedge clk) disable iff (rst)
    state == S_GAP |=> state == S_WRITE || hold_on)
    else $error("idle gap not exactly one clock");
  a_resp_min: assert property (@(posedge clk) disable iff (rst)
    state == S_IDLE ##1 state == S_RESP |-> ##3 state == S_RESP)
    else $error("response shorter than four clocks");
  a_release: assert property (@(posedge clk) disable iff (rst)
    state == S_REL |=> !bus_grant)
    else $error("bus not released after unit");
  a_prio_pick: assert property (@(posedge clk) disable iff (rst)
    |granted && eligible[0] |-> granted[0])
    else $error("channel 0 not served first");
  a_half_even: assert property (@(posedge clk) disable iff (rst)
    bus_valid && bus_cmd.size == 2'h1 |-> !bus_cmd.addr[0])
    else $error("odd halfword address driven");
  a_hold_stop: assert property (@(posedge clk) disable iff (rst)
    hold_on && bus_valid |=> !bus_valid)
    else $error("bus cycle kept under hold");
  a_one_grant: assert property (@(posedge clk) disable iff (rst)
    $onehot0(granted))
    else $error("two channels granted at once");
  a_write_data: assert property (@(posedge clk) disable iff (rst)
    state == S_WRITE |-> fifo_out_valid)
    else $error("write cycle with no data read");

  // scenarios worth reaching; the last two prove a request can wait
  c_two_reads: cover property (@(posedge clk) rd_total == 3'h2
    && state == S_GAP);
  c_two_writes: cover property (@(posedge clk) wr_total == 3'h2
    && state == S_REL);
  c_hold_abort: cover property (@(posedge clk) hold_on
    && state == S_READ);
  c_prio_wait: cover property (@(posedge clk) |granted
    && eligible != granted);
  c_pend_off: cover property (@(posedge clk) |request_pending_flag
    && !any_req);
endmodule : fcdma_top

// ===== tb/fcdma_bus_model.sv
/*
  fcdma_bus_model: shared system bus seen from the controller; byte at
  address a reads a[7:0]^5A, writes are absorbed.
  Assumes bus_cmd stands until bus_ack; lat is at least 1.
*/
`timescale 1ns/1ps
module fcdma_bus_model
  import fcdma_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  bus_valid,
  input  wire logic                  bus_grant,
  input  wire fcdma_pkg::fcdma_bus_s bus_cmd,
  input  wire logic [3:0]            lat,
  output logic                       bus_ack,
  output logic [15:0]                bus_rdata
);
  import fcdma_pkg::*;
  logic [3:0]  wait_cnt;
  logic [15:0] last;
  logic [7:0]  lo;
  ////////////////////////////////////////////////////////////////////
  // ack once a standing cycle has waited lat clocks (slow or prompt)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) wait_cnt <= 4'h0;
    else if (!bus_valid || !bus_grant || bus_ack) wait_cnt <= 4'h0;
    else wait_cnt <= wait_cnt + 4'h1;
  end
  assign bus_ack = bus_valid && bus_grant && (wait_cnt >= lat);
  ////////////////////////////////////////////////////////////////////
  // released data lines toggle so a stale value never passes
  assign lo = bus_cmd.addr[7:0] ^ 8'h5A;
  always_comb begin
    if (bus_valid && !bus_cmd.write)
      bus_rdata = (bus_cmd.size == 2'h0) ? {~lo, lo}
                : {(bus_cmd.addr[7:0] + 8'h01) ^ 8'h5A, lo};
    else bus_rdata = ~last;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) last <= 16'h0000;
    else last <= bus_rdata;
  end
endmodule : fcdma_bus_model

// ===== tb/tb_fcdma_top.sv
/*
  tb_fcdma_top: self-checking bench of the transfer controller.
  Assumes the bus model answers every cycle; addresses stay per unit.
*/
`timescale 1ns/1ps
module tb_fcdma_top;
  import fcdma_pkg::*;
  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [1:0]  size;
    logic [15:0] data;
  } fcdma_exp_s;
  logic              clk, rst, bus_hold, bus_ack, bus_req;
  logic              bus_grant, bus_valid, hw;
  fcdma_cfg_s [3:0]  cfg;
  logic [3:0]        cfg_load, soft_trigger_bit, flag_read, lat;
  logic [3:0]        system_wait_setting, request_pending_flag;
  logic [3:0]        terminal_count_flag, enable_clear, transfer_end_irq;
  logic [63:0]       periph_irq;
  logic [15:0]       bus_rdata;
  logic [3:0][15:0]  transfer_count_reg;
  fcdma_bus_s        bus_cmd;
  fcdma_exp_s        exp_q[$];
  fcdma_exp_s        e;
  int                err_count, tests_run, units, irq_seen[4];
  integer            seed;

  fcdma_top u_fcdma_top (.clk(clk), .rst(rst), .cfg(cfg),
    .cfg_load(cfg_load), .soft_trigger_bit(soft_trigger_bit),
    .flag_read(flag_read), .periph_irq(periph_irq),
    .system_wait_setting(system_wait_setting), .bus_hold(bus_hold),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata), .bus_req(bus_req),
    .bus_grant(bus_grant), .bus_cmd(bus_cmd), .bus_valid(bus_valid),
    .request_pending_flag(request_pending_flag),
    .terminal_count_flag(terminal_count_flag),
    .enable_clear(enable_clear), .transfer_end_irq(transfer_end_irq),
    .transfer_count_reg(transfer_count_reg));
  fcdma_bus_model u_fcdma_bus_model (.clk(clk), .rst(rst),
    .bus_valid(bus_valid), .bus_grant(bus_grant), .bus_cmd(bus_cmd),
    .lat(lat), .bus_ack(bus_ack), .bus_rdata(bus_rdata));

  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want,
                       input string msg);
    tests_run++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch %0t: %s seen %h want %h", $time, msg, seen, want);
    end
  endtask : check
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  task automatic put(input logic w, input logic [31:0] a,
                     input logic [1:0] s, input logic [15:0] d);
    exp_q.push_back({w, a, s, d});
  endtask : put
  // expected bus cycles of one unit, reads first
  task automatic expect_unit(input int ch);
    logic [31:0] sa, da;
    logic [7:0]  b0, b1;
    sa = cfg[ch].src_addr;
    da = cfg[ch].dst_addr;
    if (cfg[ch].half) begin
      sa[0] = 1'b0;
      da[0] = 1'b0;
    end
    b0 = sa[7:0] ^ 8'h5A;
    b1 = (sa[7:0] + 8'h01) ^ 8'h5A;
    if (!cfg[ch].half) begin
      put(1'b0, sa, 2'h0, 16'h0000);
      put(1'b1, da, 2'h0, {8'h00, b0});
    end else begin
      if (cfg[ch].src_region == REG_EXT8) begin
        put(1'b0, sa, 2'h0, 16'h0000);
        put(1'b0, sa + 32'h1, 2'h0, 16'h0000);
      end else put(1'b0, sa, 2'h1, 16'h0000);
      if (cfg[ch].dst_region == REG_EXT8) begin
        put(1'b1, da, 2'h0, {8'h00, b0});
        put(1'b1, da + 32'h1, 2'h0, {8'h00, b1});
      end else put(1'b1, da, 2'h1, {b1, b0});
    end
    units++;
  endtask : expect_unit
  task automatic setup(input int ch, input logic en, input logic h,
                       input logic [1:0] sr, input logic [1:0] dr,
                       input logic [5:0] sel);
    cfg[ch].enable = en;
    cfg[ch].half = h;
    cfg[ch].src_region = sr;
    cfg[ch].dst_region = dr;
    cfg[ch].source_sel = sel;
    cfg[ch].src_addr = $random(seed);
    cfg[ch].dst_addr = $random(seed);
    cfg[ch].count = 16'h0001;
    cfg_load[ch] = 1'b1;
    @(negedge clk);
    cfg_load = 4'h0;
    @(negedge clk);
  endtask : setup
  task automatic pulse_soft(input int ch);
    soft_trigger_bit[ch] = 1'b1;
    @(negedge clk);
    soft_trigger_bit = 4'h0;
  endtask : pulse_soft
  task automatic clear_tc();
    flag_read = 4'hF;
    @(negedge clk);
    flag_read = 4'h0;
    @(negedge clk);
  endtask : clear_tc
  task automatic wait_done();
    int n;
    n = 0;
    repeat (3) @(negedge clk);
    while ((bus_req || exp_q.size() != 0) && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (n >= 500) check(32'h0, 32'h1, "transfer hang");
    repeat (2) @(negedge clk);
  endtask : wait_done
  ////////////////////////////////////////////////////////////////////
  // watcher: each acked cycle takes the oldest note off the queue
  always @(posedge clk) begin
    if (!rst && bus_valid && bus_ack) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0, "extra cycle");
      else begin
        e = exp_q.pop_front();
        check(bus_cmd.write, e.write, "cycle kind");
        check(bus_cmd.addr, e.addr, "address");
        check(bus_cmd.size, e.size, "size");
        if (e.write) check(e.size[0] ? bus_cmd.wdata
          : {8'h00, bus_cmd.wdata[7:0]}, e.data, "data");
      end
    end
    for (int i = 0; i < 4; i++) if (transfer_end_irq[i]) irq_seen[i]++;
  end
  // software drops enable when the controller asks
  always @(negedge clk)
    for (int i = 0; i < 4; i++)
      if (enable_clear[i]) cfg[i].enable <= 1'b0;
  initial begin
    repeat (25000) @(posedge clk);
    err_count++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h4cb1;
    clk = 1'b0; rst = 1'b1; cfg = '0; cfg_load = 4'h0; bus_hold = 1'b0;
    soft_trigger_bit = 4'h0; flag_read = 4'h0; periph_irq = '0;
    lat = 4'h1; system_wait_setting = 4'($random(seed) & 3);
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check({request_pending_flag, terminal_count_flag, bus_valid}, 0, "reset");
    // repeat trigger in flight is dropped, count steps by one
    setup(0, 1'b1, 1'b0, REG_RAM, REG_RAM, SEL_NONE);
    cfg[0].count = 16'h0002;
    cfg_load = 4'h1; @(negedge clk); cfg_load = 4'h0;
    expect_unit(0); pulse_soft(0);
    repeat (5) @(negedge clk);
    pulse_soft(0);
    wait_done();
    check(transfer_count_reg[0], 16'h0001, "count step");
    check(terminal_count_flag[0], 1'b0, "no early terminal");
    $display("test repeat_dropped done");
    // every region pair and size; peripheral only halfword
    for (int k = 0; k < 32; k++) begin
      hw = k[4];
      if (!hw && (k[3:2] == 0 || k[1:0] == 0)) continue;
      lat = 4'($random(seed) & 3) + 4'h1;
      setup(1, 1'b1, hw, k[3:2], k[1:0], SEL_NONE);
      expect_unit(1); pulse_soft(1); wait_done();
      check(terminal_count_flag[1], 1'b1, "terminal");
      check(cfg[1].enable, 1'b0, "enable cleared");
      cfg[1].enable = 1'b1;
      pulse_soft(1); wait_done();
      clear_tc();
      check(terminal_count_flag[1], 1'b0, "flag read");
    end
    check(irq_seen[1], units - 1, "end irq count");
    $display("test width_matrix done");
    // disabled soft trigger, zero selector, pending while disabled
    setup(2, 1'b0, 1'b1, REG_RAM, REG_EXT8, 6'h05);
    setup(3, 1'b1, 1'b0, REG_RAM, REG_RAM, SEL_NONE);
    pulse_soft(2);
    periph_irq[0] = 1'b1; @(negedge clk); periph_irq = '0;
    repeat (8) @(negedge clk);
    check(request_pending_flag, 4'h0, "no request");
    periph_irq[5] = 1'b1; @(negedge clk); periph_irq = '0;
    repeat (8) @(negedge clk);
    check(request_pending_flag[2], 1'b1, "pending while off");
    expect_unit(2); cfg[2].enable = 1'b1; wait_done();
    check(request_pending_flag[2], 1'b0, "pending served");
    clear_tc();
    $display("test pending done");
    // four simultaneous hardware requests served by priority
    for (int c = 3; c >= 0; c--) setup(c, 1'b1, 1'b1, REG_RAM,
                                       REG_PERI, 6'(c + 1));
    for (int c = 0; c < 4; c++) expect_unit(c);
    periph_irq[4:1] = 4'hF; @(negedge clk); periph_irq = '0;
    wait_done();
    check(terminal_count_flag, 4'hF, "all served");
    clear_tc();
    $display("test priority done");
    // bus hold in mid-read aborts, unit resumes once
    lat = 4'h4;
    setup(0, 1'b1, 1'b1, REG_EXT8, REG_RAM, SEL_NONE);
    expect_unit(0);
    // the byte read acked as the hold lands is issued again on resume
    exp_q.push_front(exp_q[0]);
    pulse_soft(0);
    repeat (6) @(negedge clk);
    bus_hold = 1'b1;
    repeat (6) @(negedge clk);
    check({bus_req, bus_valid, bus_grant}, 3'h4, "under hold");
    bus_hold = 1'b0;
    wait_done();
    check(terminal_count_flag[0], 1'b1, "resumed");
    $display("test bus_hold done");
    finish_test();
  end
endmodule : tb_fcdma_top
